// File: core/dbgp_consts.svh
`ifndef DBGP_CONSTS_SVH
`define DBGP_CONSTS_SVH

// Register placement inside the controller's memory space
`define DBGP_CS_OFFSET   8'hA0
`define DBGP_CS_RESET    32'h0000_0000

// Field positions of the control/status word
`define DBGP_OWNER_BIT   30
`define DBGP_ENABLE_BIT  28
`define DBGP_DONE_BIT    16
`define DBGP_LINK_MSB    15
`define DBGP_LINK_LSB    12
`define DBGP_RSVD11_BIT  11
`define DBGP_CLAIM_BIT   10
`define DBGP_EXC_MSB     9
`define DBGP_EXC_LSB     7
`define DBGP_ERR_BIT     6
`define DBGP_GO_BIT      5
`define DBGP_WRITE_BIT   4
`define DBGP_LEN_MSB     3
`define DBGP_LEN_LSB     0

// Field reset values
`define DBGP_LEN_RESET   4'h0
`define DBGP_EXC_RESET   3'h0

// Power state codes
`define DBGP_PWR_D0      2'h0
`define DBGP_PWR_D3      2'h3

`endif

// File: core/dbgp_pkg.sv
package dbgp_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    REQ_IDLE = 2'b01,
    REQ_BUSY = 2'b10
  } req_state_t;

  typedef struct packed {
    logic       owner_force;
    logic       claim;
    logic       done;
    logic       go;
    logic       write_dir;
    logic [3:0] data_len;
    logic       err;
    logic [2:0] exc;
    req_state_t req_state;
    logic [1:0] pwr_prev;
    word_t      rdata;
    logic       rvalid;
    logic       route;
    logic       req_start;
  } cs_state_t;

  typedef struct packed {
    logic enable;
  } track_state_t;

endpackage

// File: core/dbgp_if.sv
`timescale 1ns/1ps

interface dbgp_if;
  logic ce;
  logic clear;
  logic sw_wr;
  logic sw_val;
  logic root_enabled;
  logic root_change;
  logic enable_flag;

  modport ctrl (
    output ce,
    output clear,
    output sw_wr,
    output sw_val,
    output root_enabled,
    output root_change,
    input  enable_flag
  );

  modport track (
    input  ce,
    input  clear,
    input  sw_wr,
    input  sw_val,
    input  root_enabled,
    input  root_change,
    output enable_flag
  );
endinterface

// File: core/dbgp_enable_track.sv
`timescale 1ns/1ps

module dbgp_enable_track (
  input wire logic CORE_CLK,
  input wire logic SRST,
  dbgp_if.track    trk
);

  dbgp_pkg::track_state_t st_ff;
  dbgp_pkg::track_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (trk.sw_wr) begin
      if (!trk.sw_val) begin
        nxt_st.enable = 1'b0;
      end else if (trk.root_enabled) begin
        nxt_st.enable = 1'b1;
      end
    end
    // A disable event on the root port outranks a same-cycle software set
    if (trk.root_change) begin
      nxt_st.enable = 1'b0;
    end
    if (trk.clear) begin
      nxt_st.enable = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_ff <= '0;
    end else if (trk.ce) begin
      st_ff <= nxt_st;
    end
  end

  assign trk.enable_flag = st_ff.enable;

endmodule // dbgp_enable_track

// File: core/dbgp_ctrl_status.sv
// Notes on behaviour
// - Bus reset, controller reset and D3-to-D0 return restore every field default.
// - Illegal programming by software is neither checked nor handled.
// - Control word is 32 bits and reads zero after reset except the fixed link type field.
// - Setting ownership force routes the debug port to this controller at once.
// - If this controller already owns the port, forcing changes nothing.
// - Ownership force beats every ownership setting in standard registers.
// - Enable flag clears when software writes zero; resets to zero.
// - Enable flag clears whenever the root port enable-change would be set.
// - Software set of the enable flag works only while the root port is enabled.
// - Request-complete flag sets when a debug read or write finishes.
// - Request-complete flag clears on software write of one, and on any reset or D3-to-D0 return.
// - Link type field is read-only and returns a fixed debug port code.
// - Bit 11 always reads zero; writes to it are ignored.
// - Claim flag is plain storage with no hardware effect; zero after reset.
// - Writing one to the request trigger starts a debug transaction.
// - Request trigger clears in the same cycle request-complete sets.
`timescale 1ns/1ps
`include "dbgp_consts.svh"

module dbgp_ctrl_status #(
  parameter int unsigned ADDR_W         = 8,
  // Link type code value is arbitrary
  parameter logic [3:0]  LINK_TYPE_CODE = 4'hA
) (
  input  wire logic              CORE_CLK,
  input  wire logic              SRST,
  input  wire logic              CE,
  input  wire logic              PCI_BUS_RESET_N,
  input  wire logic              HOST_CONTROLLER_RESET,
  input  wire logic [1:0]        POWER_STATE,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [31:0]       REG_WDATA,
  output logic      [31:0]       REG_RDATA,
  output logic                   REG_RVALID,
  input  wire logic              ROOT_PORT_ENABLED,
  input  wire logic              ROOT_PORT_ENABLE_CHANGE,
  input  wire logic              STD_OWNER_ENHANCED,
  output logic                   ROUTE_TO_ENHANCED,
  output logic                   DEBUG_PORT_ENABLE,
  output logic                   REQ_START,
  output logic                   REQ_WRITE,
  output logic      [3:0]        REQ_LEN,
  input  wire logic              REQ_DONE,
  input  wire logic              REQ_ERROR,
  input  wire logic [2:0]        REQ_EXCEPTION,
  input  wire logic [3:0]        REQ_RD_LEN
);

  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W too narrow to reach the control word offset");
  end

  localparam logic [ADDR_W-1:0] CS_ADDR = ADDR_W'(`DBGP_CS_OFFSET);

  dbgp_pkg::cs_state_t st_ff;
  dbgp_pkg::cs_state_t nxt_st;

  dbgp_if link ();

  logic soft_clear;
  logic d3_to_d0;
  logic cs_hit_wr;
  logic cs_hit_rd;
  logic go_write;
  logic finish;

  // Assemble the readable control word from the stored fields
  function automatic dbgp_pkg::word_t compose(
    input dbgp_pkg::cs_state_t s,
    input logic                en
  );
    dbgp_pkg::word_t w;
    w                                   = `DBGP_CS_RESET;
    w[`DBGP_OWNER_BIT]                  = s.owner_force;
    w[`DBGP_ENABLE_BIT]                 = en;
    w[`DBGP_DONE_BIT]                   = s.done;
    w[`DBGP_LINK_MSB:`DBGP_LINK_LSB]    = LINK_TYPE_CODE;
    w[`DBGP_RSVD11_BIT]                 = 1'b0;
    w[`DBGP_CLAIM_BIT]                  = s.claim;
    w[`DBGP_EXC_MSB:`DBGP_EXC_LSB]      = s.exc;
    w[`DBGP_ERR_BIT]                    = s.err;
    w[`DBGP_GO_BIT]                     = s.go;
    w[`DBGP_WRITE_BIT]                  = s.write_dir;
    w[`DBGP_LEN_MSB:`DBGP_LEN_LSB]      = s.data_len;
    return w;
  endfunction

  // Power state return from D3 counts as a reset of this register
  assign d3_to_d0   = (st_ff.pwr_prev == `DBGP_PWR_D3) && (POWER_STATE == `DBGP_PWR_D0);

  assign soft_clear = !PCI_BUS_RESET_N || HOST_CONTROLLER_RESET || d3_to_d0;

  assign cs_hit_wr  = REG_WR && (REG_ADDR == CS_ADDR);
  assign cs_hit_rd  = REG_RD && (REG_ADDR == CS_ADDR);

  // Trigger write is ignored while a request is already busy; such use is undefined
  assign go_write   = cs_hit_wr && REG_WDATA[`DBGP_GO_BIT];

  assign finish     = REQ_DONE && (st_ff.req_state == dbgp_pkg::REQ_BUSY);

  // Enable flag bookkeeping lives in the tracker
  assign link.ce           = CE;
  assign link.clear        = soft_clear;
  assign link.sw_wr        = cs_hit_wr;
  assign link.sw_val       = REG_WDATA[`DBGP_ENABLE_BIT];
  assign link.root_enabled = ROOT_PORT_ENABLED;
  assign link.root_change  = ROOT_PORT_ENABLE_CHANGE;

  dbgp_enable_track u_track (
    .CORE_CLK (CORE_CLK),
    .SRST     (SRST),
    .trk      (link)
  );

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.pwr_prev  = POWER_STATE;
    nxt_st.req_start = 1'b0;
    nxt_st.rvalid    = 1'b0;

    // Software writes to the writable fields
    if (cs_hit_wr) begin
      nxt_st.owner_force = REG_WDATA[`DBGP_OWNER_BIT];
      nxt_st.claim       = REG_WDATA[`DBGP_CLAIM_BIT];
      nxt_st.write_dir   = REG_WDATA[`DBGP_WRITE_BIT];
      nxt_st.data_len    = REG_WDATA[`DBGP_LEN_MSB:`DBGP_LEN_LSB];
      if (REG_WDATA[`DBGP_DONE_BIT]) begin
        nxt_st.done = 1'b0;
      end
    end

    unique case (st_ff.req_state)
      dbgp_pkg::REQ_IDLE: begin
        if (go_write) begin
          nxt_st.go        = 1'b1;
          nxt_st.req_start = 1'b1;
          nxt_st.req_state = dbgp_pkg::REQ_BUSY;
        end
      end
      dbgp_pkg::REQ_BUSY: begin
        if (finish) begin
          // Completion outranks a same-cycle clear of the complete flag
          nxt_st.done      = 1'b1;
          nxt_st.go        = 1'b0;
          nxt_st.err       = REQ_ERROR;
          nxt_st.exc       = REQ_EXCEPTION;
          nxt_st.req_state = dbgp_pkg::REQ_IDLE;
          if (!st_ff.write_dir) begin
            nxt_st.data_len = REQ_RD_LEN;
          end
        end
      end
    endcase

    // Force overrides the standard ownership bits; already-owned stays owned
    nxt_st.route = nxt_st.owner_force || STD_OWNER_ENHANCED;

    if (cs_hit_rd) begin
      nxt_st.rdata  = compose(st_ff, link.enable_flag);
      nxt_st.rvalid = 1'b1;
    end else if (REG_RD) begin
      // Other offsets belong to neighbouring registers; answer zero
      nxt_st.rdata  = `DBGP_CS_RESET;
      nxt_st.rvalid = 1'b1;
    end

    if (soft_clear) begin
      nxt_st.owner_force = 1'b0;
      nxt_st.claim       = 1'b0;
      nxt_st.done        = 1'b0;
      nxt_st.go          = 1'b0;
      nxt_st.write_dir   = 1'b0;
      nxt_st.data_len    = `DBGP_LEN_RESET;
      nxt_st.err         = 1'b0;
      nxt_st.exc         = `DBGP_EXC_RESET;
      nxt_st.req_state   = dbgp_pkg::REQ_IDLE;
      nxt_st.req_start   = 1'b0;
      nxt_st.route       = STD_OWNER_ENHANCED;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_ff.owner_force <= 1'b0;
      st_ff.claim       <= 1'b0;
      st_ff.done        <= 1'b0;
      st_ff.go          <= 1'b0;
      st_ff.write_dir   <= 1'b0;
      st_ff.data_len    <= `DBGP_LEN_RESET;
      st_ff.err         <= 1'b0;
      st_ff.exc         <= `DBGP_EXC_RESET;
      st_ff.req_state   <= dbgp_pkg::REQ_IDLE;
      st_ff.pwr_prev    <= `DBGP_PWR_D0;
      st_ff.rdata       <= `DBGP_CS_RESET;
      st_ff.rvalid      <= 1'b0;
      st_ff.route       <= 1'b0;
      st_ff.req_start   <= 1'b0;
    end else if (CE) begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA         = st_ff.rdata;
  assign REG_RVALID        = st_ff.rvalid;
  assign ROUTE_TO_ENHANCED = st_ff.route;
  assign DEBUG_PORT_ENABLE = link.enable_flag;
  assign REQ_START         = st_ff.req_start;
  assign REQ_WRITE         = st_ff.write_dir;
  assign REQ_LEN           = st_ff.data_len;

endmodule // dbgp_ctrl_status

// File: test/dbgp_ctrl_status_props.sv
`timescale 1ns/1ps
module dbgp_ctrl_status_props #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              CORE_CLK,
  input wire logic              SRST,
  input wire logic              CE,
  input wire logic              PCI_BUS_RESET_N,
  input wire logic              HOST_CONTROLLER_RESET,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0]       REG_WDATA,
  input wire logic [31:0]       REG_RDATA,
  input wire logic              REG_RVALID,
  input wire logic              ROOT_PORT_ENABLED,
  input wire logic              ROOT_PORT_ENABLE_CHANGE,
  input wire logic              STD_OWNER_ENHANCED,
  input wire logic              ROUTE_TO_ENHANCED,
  input wire logic              DEBUG_PORT_ENABLE,
  input wire logic              REQ_START
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  sequence force_wr;
    CE && REG_WR && REG_ADDR == 'hA0 && REG_WDATA[30] && PCI_BUS_RESET_N
      && !HOST_CONTROLLER_RESET ##1 CE;
  endsequence
  a_read_answer: assert property (REG_RD && CE |=> REG_RVALID)
    else $error("read not answered");
  a_reserved_zero: assert property (REG_RVALID |-> !REG_RDATA[31] && !REG_RDATA[29]
    && REG_RDATA[27:17] == 11'h0 && !REG_RDATA[11]) else $error("reserved bit set");
  a_force_route: assert property (force_wr |=> ROUTE_TO_ENHANCED)
    else $error("force did not route");
  a_std_route: assert property (STD_OWNER_ENHANCED && CE |=> ROUTE_TO_ENHANCED)
    else $error("standard owner lost");
  a_enable_gate: assert property ($rose(DEBUG_PORT_ENABLE) |-> $past(ROOT_PORT_ENABLED))
    else $error("enable without root port");
  a_enable_drop: assert property (ROOT_PORT_ENABLE_CHANGE && CE |=> !DEBUG_PORT_ENABLE)
    else $error("enable kept after change");
  a_start_pulse: assert property (REQ_START |-> $past(REG_WR) && $past(REG_WDATA[5])
    ##1 !REQ_START) else $error("bad start pulse");
  a_hc_clear: assert property (HOST_CONTROLLER_RESET && CE |=> !DEBUG_PORT_ENABLE
    && !REQ_START) else $error("controller reset ignored");
endmodule // dbgp_ctrl_status_props

bind dbgp_ctrl_status dbgp_ctrl_status_props #(.ADDR_W(ADDR_W)) u_props (.*);

// File: test/dbgp_engine_model.sv
`timescale 1ns/1ps
module dbgp_engine_model #(
  parameter int LAT = 3
) (
  input wire logic  clk,
  input wire logic  start,
  output logic      done,
  output logic      error,
  output logic [2:0] exc,
  output logic [3:0] rd_len
);
  // Status lines show the inverse answer outside the done pulse
  initial begin
    done = 1'b0;
    {error, exc, rd_len} = 8'h57;
    forever begin
      @(posedge clk);
      if (start) begin
        repeat (LAT) @(negedge clk);
        done = 1'b1;
        {error, exc, rd_len} = 8'hA8;
        @(negedge clk);
        done = 1'b0;
        {error, exc, rd_len} = 8'h57;
      end
    end
  end
endmodule // dbgp_engine_model

// File: test/test_usb_debug_port_control_status.sv
`timescale 1ns/1ps
`include "dbgp_consts.svh"
module test_usb_debug_port_control_status;
  localparam logic [3:0]  LT = 4'h5; // Arbitrary link type code
  localparam logic [31:0] LW = {16'h0, LT, 12'h0};
  logic        CORE_CLK = 0, SRST = 1, CE = 1, PCI_BUS_RESET_N = 1, HOST_CONTROLLER_RESET = 0;
  logic        REG_WR = 0, REG_RD = 0, ROOT_PORT_ENABLED = 0, ROOT_PORT_ENABLE_CHANGE = 0;
  logic        STD_OWNER_ENHANCED = 0, REG_RVALID, ROUTE_TO_ENHANCED, DEBUG_PORT_ENABLE;
  logic        REQ_START, REQ_WRITE, REQ_DONE, REQ_ERROR;
  logic [1:0]  POWER_STATE = 2'h0;
  logic [7:0]  REG_ADDR = 8'h0;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
  logic [2:0]  REQ_EXCEPTION;
  logic [3:0]  REQ_LEN, REQ_RD_LEN;
  int          fails = 0, check_count = 0;
  dbgp_ctrl_status #(.LINK_TYPE_CODE(LT)) u_dut (.*);
  dbgp_engine_model u_eng (.clk(CORE_CLK), .start(REQ_START), .done(REQ_DONE),
    .error(REQ_ERROR), .exc(REQ_EXCEPTION), .rd_len(REQ_RD_LEN));
  always #50 CORE_CLK = ~CORE_CLK;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] v);
    @(negedge CORE_CLK);
    REG_WR = 1'b1;
    REG_ADDR = `DBGP_CS_OFFSET;
    REG_WDATA = v;
    @(negedge CORE_CLK);
    REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge CORE_CLK);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge CORE_CLK);
    chk(32'(REG_RVALID), 32'h1);
    REG_RD = 1'b0;
    v = REG_RDATA;
  endtask
  task automatic settle();
    repeat (2) @(negedge CORE_CLK);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    test_done();
  end
  initial begin
    logic [31:0] wv [2] = '{32'h0000_0035, 32'h0001_0020};
    logic [31:0] ev [2] = '{32'h0001_0155, 32'h0001_0148};
    repeat (2) @(negedge CORE_CLK);
    SRST = 1'b0;
    rd(8'hA0, d); chk(d, LW);
    rd(8'hA4, d); chk(d, 32'h0);
    // Root port off: enable write refused, reserved and status bits not writable
    wr(32'hFFFF_FFDF); rd(8'hA0, d); chk(d, LW | 32'h4000_041F);
    chk(32'(ROUTE_TO_ENHANCED), 32'h1);
    wr(32'h0); settle(); chk(32'(ROUTE_TO_ENHANCED), 32'h0);
    STD_OWNER_ENHANCED = 1'b1; settle(); chk(32'(ROUTE_TO_ENHANCED), 32'h1);
    wr(32'h4000_0000); settle(); chk(32'(ROUTE_TO_ENHANCED), 32'h1);
    STD_OWNER_ENHANCED = 1'b0; settle(); chk(32'(ROUTE_TO_ENHANCED), 32'h1);
    ROOT_PORT_ENABLED = 1'b1;
    wr(32'h1000_0000); settle(); chk(32'(DEBUG_PORT_ENABLE), 32'h1);
    ROOT_PORT_ENABLE_CHANGE = 1'b1; @(negedge CORE_CLK); ROOT_PORT_ENABLE_CHANGE = 1'b0;
    settle(); chk(32'(DEBUG_PORT_ENABLE), 32'h0);
    wr(32'h1000_0000); wr(32'h0); settle(); chk(32'(DEBUG_PORT_ENABLE), 32'h0);
    // Second request also clears the old completion in the same write
    for (int i = 0; i < 2; i++) begin
      wr(wv[i]); chk({27'h0, REQ_WRITE, REQ_LEN}, {27'h0, wv[i][4:0]});
      d = 32'h0;
      for (int n = 0; n < 20 && !d[16]; n++) rd(8'hA0, d);
      chk(d, ev[i] | LW);
    end
    wr(32'h0); rd(8'hA0, d); chk(d, 32'h0001_0140 | LW);
    wr(32'h0001_0000); rd(8'hA0, d); chk(d, 32'h0000_0140 | LW);
    // Clock enable low must swallow a write entirely
    CE = 1'b0;
    wr(32'h4000_0400);
    CE = 1'b1;
    rd(8'hA0, d); chk(d, 32'h0000_0140 | LW);
    chk(32'(ROUTE_TO_ENHANCED), 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(32'h1000_0400);
      @(negedge CORE_CLK);
      case (k)
        0: HOST_CONTROLLER_RESET = 1'b1;
        1: PCI_BUS_RESET_N = 1'b0;
        default: POWER_STATE = 2'h3;
      endcase
      @(negedge CORE_CLK);
      HOST_CONTROLLER_RESET = 1'b0;
      PCI_BUS_RESET_N = 1'b1;
      POWER_STATE = 2'h0;
      @(negedge CORE_CLK);
      rd(8'hA0, d); chk(d, LW);
    end
    test_done();
  end
endmodule // test_usb_debug_port_control_status
